// ---- rtl/ezbi_pkg.sv ----
// Purpose: Shared constants and bus clock divider for the zone interface
// Assumes: clk_in is twice the system clock rate
// Notes: Package first, then the divider module
`timescale 1ns/1ps
package ezbi_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 16;
    localparam int ZONE_W = 3;
    localparam int LEAD_W = 2;
    localparam int ACT_W = 3;
    localparam int TRAIL_W = 2;
    localparam int CNT_W = 3;
    // Config word bit positions
    localparam int CFG_RATIO_LSB = 0;
    localparam int CFG_READY_ASYNC = 2;
    localparam int CFG_CLK_OFF = 3;
    localparam int CFG_W = 4;
    // Divider ratio codes
    localparam logic [1:0] RATIO_EQUAL = 2'h0;
    localparam logic [1:0] RATIO_HALF = 2'h1;
    localparam logic [1:0] RATIO_QUARTER = 2'h2;
    // Reset value: quarter rate, clock running, sync ready
    localparam logic [3:0] CFG_RESET = 4'h2;
    // Half periods in clk_in cycles minus one
    localparam logic [1:0] HALF_EQUAL = 2'h0;
    localparam logic [1:0] HALF_HALF = 2'h1;
    localparam logic [1:0] HALF_QUARTER = 2'h3;
    typedef enum logic [2:0] {
        EZBI_IDLE = 3'b000,
        EZBI_LEAD = 3'b001,
        EZBI_ACTIVE = 3'b010,
        EZBI_TRAIL = 3'b011,
        EZBI_HOLD = 3'b100
    } ezbi_state_t;
endpackage

// ==========================================================
// Bus clock divider
module ezbi_clk_div (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic [1:0] ratio_in,
    input wire logic clk_off_in,
    output logic bus_clk_out
);
    logic [1:0] cnt;
    wire [1:0] half_lim = (ratio_in == ezbi_pkg::RATIO_EQUAL) ?
        ezbi_pkg::HALF_EQUAL : (ratio_in == ezbi_pkg::RATIO_HALF) ?
        ezbi_pkg::HALF_HALF : ezbi_pkg::HALF_QUARTER;
    wire tick = (cnt >= half_lim);
    wire quarter_run = !clk_off_in && (ratio_in == ezbi_pkg::RATIO_QUARTER);

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cnt <= 2'h0;
            bus_clk_out <= 1'b0;
        end else if (clk_off_in) begin
            cnt <= 2'h0;
            bus_clk_out <= 1'b0;
        end else begin
            cnt <= tick ? 2'h0 : cnt + 2'h1;
            if (tick) begin
                bus_clk_out <= ~bus_clk_out;
            end
        end
    end

    AST_CLK_OFF: assert property (
        @(posedge clk_in) disable iff (reset_in)
        clk_off_in |=> !bus_clk_out)
        else $error("bus clock runs while disabled");
    // Spacing judged only while quarter rate stays selected
    AST_CLK_QUARTER: assert property (
        @(posedge clk_in) disable iff (reset_in)
        (quarter_run && tick) ##1 quarter_run [*4]
        |-> tick && !$past(tick) && !$past(tick, 2) && !$past(tick, 3))
        else $error("quarter rate half period not four cycles");
endmodule

// ---- rtl/ezbi_core.sv ----
// Purpose: Zone bus master with strobe timing, ready wait and hold grant
// Assumes: Pin inputs are asynchronous; user side is on clk_in
// Notes: All pin outputs are registered; pins lag state by one cycle
// Function
// - Drive grant ack low once hold granted
// - Tri-state all bus and strobes while granted
// - Release grant ack when request released
// - Low-pair select low for zone 0/1
// - Zone two select low for zone 2
// - High-pair select low for zone 6/7
// - Write strobe timed by per-zone lead/active/trail
// - Read strobe timed by per-zone lead/active/trail
// - Read and write strobes never together
// - Read-not-write low only during writes
// - Access ends only on ready high in zones with their use-ready bit set
// - Ready sampling selectable sync or async
// - Bus clock equal, half or quarter rate
// - Bus clock quarter rate after reset
// - Clock-off bit 3 stops bus clock
// - Grant only when idle and nothing pending
// - Nineteen bit address output bus
// - Sixteen bit two-way data bus
`timescale 1ns/1ps
module ezbi_core (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [2:0] req_zone_in,
    input wire logic [18:0] req_addr_in,
    input wire logic [15:0] req_wdata_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic [15:0] rsp_rdata_out,
    input wire logic cfg_wr_in,
    input wire logic [3:0] ext_if_config_in,
    output logic [3:0] ext_if_config_out,
    input wire logic [15:0] zone_lead_in,
    input wire logic [23:0] zone_active_in,
    input wire logic [15:0] zone_trail_in,
    input wire logic [7:0] zone_use_ready_in,
    output logic [18:0] ext_addr_out,
    output logic [15:0] ext_data_out,
    input wire logic [15:0] ext_data_in,
    output logic ext_data_oe_out,
    output logic cs_zone_low_pair_n_out,
    output logic cs_zone_two_n_out,
    output logic cs_zone_high_pair_n_out,
    output logic wr_strobe_n_out,
    output logic rd_strobe_n_out,
    output logic read_not_write_out,
    output logic ctl_oe_out,
    input wire logic ext_ready_in,
    input wire logic bus_request_n_in,
    output logic bus_grant_ack_n_out,
    output logic ext_bus_clk_out
);
    ezbi_pkg::ezbi_state_t state, next_state;
    logic [2:0] cnt;
    logic [2:0] cur_zone;
    logic cur_write;
    logic [18:0] cur_addr;
    logic [15:0] cur_wdata;
    logic rdy_s1, rdy_s2, rdy_s3;
    logic hreq_s1, hreq_s2;
    logic [15:0] data_s1, data_s2;
    logic [3:0] acc_hist;
    logic rsp_pend;

    // ==========================================================
    // Pin synchronisers
    always_ff @(posedge clk_in) begin
        rdy_s1 <= ext_ready_in;
        rdy_s2 <= rdy_s1;
        rdy_s3 <= rdy_s2;
        hreq_s1 <= bus_request_n_in;
        hreq_s2 <= hreq_s1;
        data_s1 <= ext_data_in;
        data_s2 <= data_s1;
    end

    // ==========================================================
    // Phase decode
    function automatic logic [2:0] lim(input logic [2:0] v);
        lim = (v == 3'h0) ? 3'h1 : v;
    endfunction

    wire hold_req = ~hreq_s2;
    wire ready_async = ext_if_config_out[ezbi_pkg::CFG_READY_ASYNC];
    // Async mode needs two agreeing samples
    wire rdy_ok = ready_async ? (rdy_s2 & rdy_s3) : rdy_s2;
    // Ready samples taken before the select went out are stale pull-up
    wire rdy_fresh = ready_async ? (&acc_hist) : (&acc_hist[2:0]);
    wire rdy_seen = rdy_ok & rdy_fresh;
    wire [1:0] lead_f = zone_lead_in[cur_zone*2 +: 2];
    wire [2:0] act_f = zone_active_in[cur_zone*3 +: 3];
    wire [1:0] trail_f = zone_trail_in[cur_zone*2 +: 2];
    wire use_rdy = zone_use_ready_in[cur_zone];
    wire [2:0] phase_lim = (state == ezbi_pkg::EZBI_LEAD) ?
        lim({1'b0, lead_f}) : (state == ezbi_pkg::EZBI_ACTIVE) ?
        lim(act_f) : lim({1'b0, trail_f});
    wire last = (cnt >= phase_lim - 3'h1);
    wire accept = req_valid_in & req_ready_out;
    wire zone_ok = (req_zone_in[2:1] == 2'h0) || (req_zone_in == 3'h2) ||
        (req_zone_in[2:1] == 2'h3);
    wire in_access = (state == ezbi_pkg::EZBI_LEAD) ||
        (state == ezbi_pkg::EZBI_ACTIVE) || (state == ezbi_pkg::EZBI_TRAIL);
    wire act_done = last & (~use_rdy | rdy_seen);
    wire strobe_on = (state == ezbi_pkg::EZBI_ACTIVE);

    // ==========================================================
    // Access sequencer
    always_comb begin
        next_state = state;
        case (state)
            ezbi_pkg::EZBI_IDLE: begin
                if (accept && zone_ok) begin
                    next_state = ezbi_pkg::EZBI_LEAD;
                end else if (!req_valid_in && hold_req) begin
                    next_state = ezbi_pkg::EZBI_HOLD;
                end
            end
            ezbi_pkg::EZBI_LEAD: begin
                if (last) begin
                    next_state = ezbi_pkg::EZBI_ACTIVE;
                end
            end
            ezbi_pkg::EZBI_ACTIVE: begin
                if (act_done) begin
                    next_state = ezbi_pkg::EZBI_TRAIL;
                end
            end
            ezbi_pkg::EZBI_TRAIL: begin
                if (last) begin
                    next_state = ezbi_pkg::EZBI_IDLE;
                end
            end
            ezbi_pkg::EZBI_HOLD: begin
                if (!hold_req) begin
                    next_state = ezbi_pkg::EZBI_IDLE;
                end
            end
            default: next_state = ezbi_pkg::EZBI_IDLE;
        endcase
    end

    wire [2:0] next_cnt = (next_state != state) ? 3'h0 : cnt + 3'h1;
    wire trail_done = (state == ezbi_pkg::EZBI_TRAIL) & last;
    // Response waits a cycle so the read sample has crossed the syncs
    wire next_rsp = (accept & ~zone_ok) | rsp_pend;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            state <= ezbi_pkg::EZBI_IDLE;
            cnt <= 3'h0;
            cur_zone <= 3'h0;
            cur_write <= 1'b0;
            cur_addr <= 19'h00000;
            cur_wdata <= 16'h0000;
            req_ready_out <= 1'b0;
            rsp_valid_out <= 1'b0;
            rsp_pend <= 1'b0;
            acc_hist <= 4'h0;
            rsp_rdata_out <= 16'h0000;
            ext_if_config_out <= ezbi_pkg::CFG_RESET;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            req_ready_out <= (next_state == ezbi_pkg::EZBI_IDLE);
            rsp_valid_out <= next_rsp;
            rsp_pend <= trail_done;
            acc_hist <= {acc_hist[2:0], in_access};
            if (cfg_wr_in) begin
                ext_if_config_out <= ext_if_config_in;
            end
            if (accept) begin
                cur_zone <= req_zone_in;
                cur_write <= req_write_in;
                cur_addr <= req_addr_in;
                cur_wdata <= req_wdata_in;
            end
            if (accept && !zone_ok) begin
                rsp_rdata_out <= 16'h0000;
            end else if (rsp_pend && !cur_write) begin
                rsp_rdata_out <= data_s2;
            end
        end
    end

    // ==========================================================
    // Registered pins
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ext_addr_out <= 19'h00000;
            ext_data_out <= 16'h0000;
            ext_data_oe_out <= 1'b0;
            cs_zone_low_pair_n_out <= 1'b1;
            cs_zone_two_n_out <= 1'b1;
            cs_zone_high_pair_n_out <= 1'b1;
            wr_strobe_n_out <= 1'b1;
            rd_strobe_n_out <= 1'b1;
            read_not_write_out <= 1'b1;
            ctl_oe_out <= 1'b1;
            bus_grant_ack_n_out <= 1'b1;
        end else begin
            ext_addr_out <= cur_addr;
            ext_data_out <= cur_wdata;
            ext_data_oe_out <= in_access & cur_write;
            cs_zone_low_pair_n_out <=
                ~(in_access & (cur_zone[2:1] == 2'h0));
            cs_zone_two_n_out <= ~(in_access & (cur_zone == 3'h2));
            cs_zone_high_pair_n_out <=
                ~(in_access & (cur_zone[2:1] == 2'h3));
            wr_strobe_n_out <= ~(strobe_on & cur_write);
            rd_strobe_n_out <= ~(strobe_on & ~cur_write);
            read_not_write_out <= ~(in_access & cur_write);
            ctl_oe_out <= (state != ezbi_pkg::EZBI_HOLD);
            bus_grant_ack_n_out <= (state != ezbi_pkg::EZBI_HOLD);
        end
    end

    ezbi_clk_div u_clk_div (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .ratio_in(ext_if_config_out[1:0]),
        .clk_off_in(ext_if_config_out[ezbi_pkg::CFG_CLK_OFF]),
        .bus_clk_out(ext_bus_clk_out)
    );

    // ==========================================================
    // Checks
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);

    AST_GRANT_LOW: assert property (
        state == ezbi_pkg::EZBI_HOLD |=> !bus_grant_ack_n_out)
        else $error("grant ack not low in hold");
    AST_HOLD_TRISTATE: assert property (
        !bus_grant_ack_n_out |-> !ctl_oe_out && !ext_data_oe_out)
        else $error("bus driven while granted");
    AST_RELEASE: assert property (
        (state == ezbi_pkg::EZBI_HOLD && !hold_req)
        |-> ##2 bus_grant_ack_n_out && ctl_oe_out)
        else $error("grant not released");
    AST_ONE_CS: assert property (
        (!wr_strobe_n_out || !rd_strobe_n_out)
        |-> $onehot({~cs_zone_low_pair_n_out, ~cs_zone_two_n_out,
        ~cs_zone_high_pair_n_out}))
        else $error("strobe without exactly one select");
    AST_EXCL: assert property (
        !(!wr_strobe_n_out && !rd_strobe_n_out))
        else $error("read and write strobes together");
    AST_RNW: assert property (
        (!wr_strobe_n_out |-> !read_not_write_out)
        and (!rd_strobe_n_out |-> read_not_write_out))
        else $error("read-not-write wrong during strobe");
    AST_GRANT_IDLE: assert property (
        $rose(state == ezbi_pkg::EZBI_HOLD)
        |-> $past(state) == ezbi_pkg::EZBI_IDLE && !$past(req_valid_in))
        else $error("hold granted while busy");
    AST_WAIT: assert property (
        (strobe_on && last && use_rdy && !rdy_seen)
        |=> strobe_on && $stable(cur_addr) && $stable(cur_zone)
        ##1 (!wr_strobe_n_out || !rd_strobe_n_out))
        else $error("access left active without ready");
    AST_LEAD_LEN: assert property (
        $rose(state == ezbi_pkg::EZBI_LEAD) && lead_f == 2'h2
        |-> ##2 strobe_on)
        else $error("lead phase length wrong");

    COV_READ: cover property (strobe_on && !cur_write ##1 !strobe_on);
    COV_WRITE: cover property (strobe_on && cur_write ##1 !strobe_on);
    COV_WAIT: cover property (strobe_on && last && use_rdy && !rdy_seen);
    COV_HOLD: cover property (!bus_grant_ack_n_out ##1 bus_grant_ack_n_out);
endmodule

// ---- bench/ezbi_ext_mem.sv ----
// Purpose: Memory, ready source and outside bus master at the zone pins
// Assumes: Data pins carry pull-ups
// Notes: Ready rises a set count of cycles into each select
`timescale 1ns/1ps
module ezbi_ext_mem (
    input wire logic clk_in,
    input wire logic [18:0] addr_in,
    input wire logic [15:0] dut_data_in,
    input wire logic dut_oe_in,
    input wire logic [2:0] cs_n_in,
    input wire logic wr_n_in,
    input wire logic rnw_in,
    input wire logic ctl_oe_in,
    input wire logic grant_n_in,
    input wire logic [7:0] delay_in,
    output logic [15:0] line_out,
    output logic ready_out
);
    logic [15:0] mem [16];
    logic [7:0] cnt;
    wire logic sel = ctl_oe_in && !(&cs_n_in);
    initial begin
        cnt = 8'h00;
        foreach (mem[i]) mem[i] = 16'h0000;
    end
    // Store on the trailing edge of the write strobe
    always @(posedge wr_n_in) begin
        if (ctl_oe_in)
            mem[addr_in[3:0]] <= dut_data_in;
    end
    always @(posedge clk_in) begin
        cnt <= sel ? ((cnt == 8'hFF) ? cnt : cnt + 8'h01) : 8'h00;
    end
    // Pull-up keeps ready high when nothing is selected
    assign ready_out = !sel || (cnt >= delay_in);
    // Outside master drives only while granted
    assign line_out = dut_oe_in ? dut_data_in :
        !grant_n_in ? 16'hA5A5 :
        (sel && rnw_in) ? mem[addr_in[3:0]] : 16'hFFFF;
endmodule

// ---- bench/ezbi_core_tb_top.sv ----
// Purpose: Self-checking bench for the zone bus master
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Outputs are also sampled 1 ns after the edge
`timescale 1ns/1ps
module ezbi_core_tb_top;
    logic clk_in = 0, reset_in = 1, req_valid = 0, req_write = 0;
    logic cfg_wr = 0, req_n = 1;
    logic [2:0] req_zone = 3'h0;
    logic [18:0] req_addr = 19'h00000;
    logic [15:0] req_wdata = 16'h0000;
    logic [3:0] cfg = 4'h2;
    logic [7:0] dly = 8'h00;
    wire logic req_ready, rsp_valid, data_oe, cs01, cs2, cs67, wr_n, rd_n;
    wire logic rnw, ctl_oe, ready, grant_n, bclk;
    wire logic [15:0] rdata, dout, line;
    wire logic [18:0] addr;
    wire logic [3:0] cfg_q;
    int miscompares = 0, samples_checked = 0, cycles = 0;
    ezbi_core i_dut (.clk_in(clk_in), .reset_in(reset_in),
        .req_valid_in(req_valid), .req_write_in(req_write),
        .req_zone_in(req_zone), .req_addr_in(req_addr),
        .req_wdata_in(req_wdata), .req_ready_out(req_ready),
        .rsp_valid_out(rsp_valid), .rsp_rdata_out(rdata),
        .cfg_wr_in(cfg_wr), .ext_if_config_in(cfg),
        .ext_if_config_out(cfg_q), .zone_lead_in(16'h5565),
        .zone_active_in(24'h4924A2), .zone_trail_in(16'h5555),
        .zone_use_ready_in(8'h80), .ext_addr_out(addr),
        .ext_data_out(dout), .ext_data_in(line), .ext_data_oe_out(data_oe),
        .cs_zone_low_pair_n_out(cs01), .cs_zone_two_n_out(cs2),
        .cs_zone_high_pair_n_out(cs67), .wr_strobe_n_out(wr_n),
        .rd_strobe_n_out(rd_n), .read_not_write_out(rnw),
        .ctl_oe_out(ctl_oe), .ext_ready_in(ready),
        .bus_request_n_in(req_n), .bus_grant_ack_n_out(grant_n),
        .ext_bus_clk_out(bclk));
    ezbi_ext_mem i_mem (.clk_in(clk_in), .addr_in(addr),
        .dut_data_in(dout), .dut_oe_in(data_oe),
        .cs_n_in({cs01, cs2, cs67}), .wr_n_in(wr_n), .rnw_in(rnw),
        .ctl_oe_in(ctl_oe), .grant_n_in(grant_n), .delay_in(dly),
        .line_out(line), .ready_out(ready));
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic check(input logic [31:0] seen, exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    function automatic logic [2:0] exp_cs(input logic [2:0] z);
        return (z < 2) ? 3'h3 : (z == 2) ? 3'h5 : (z > 5) ? 3'h6 : 3'h7;
    endfunction
    // Zone 1 active 4; zone 7 adds one cycle of ready sampling
    function automatic int exp_low(input logic [2:0] z);
        return (z == 3) ? 0 : (z == 1) ? 4 : (z == 7) ? 3 : 2;
    endfunction
    task automatic access(input logic wr, input logic [2:0] z,
        input logic [18:0] a, input logic [15:0] wd, input logic hold,
        output logic [15:0] rd, output int low);
        logic ok;
        low = 0;
        {req_valid, req_write, req_zone, req_addr, req_wdata} =
            {1'b1, wr, z, a, wd};
        do begin
            ok = req_ready;
            tick();
        end while (ok !== 1'b1);
        req_valid = 0;
        if (hold)
            req_n = 0;
        for (int i = 0; i < 300 && rsp_valid !== 1'b1; i++) begin
            tick();
            if (hold)
                check(grant_n, 1, "grant during access");
            if ((wr ? wr_n : rd_n) === 1'b0) begin
                low++;
                check({cs01, cs2, cs67}, exp_cs(z), "select");
                check(rnw, !wr, "rnw level");
                check(wr ? rd_n : wr_n, 1, "both strobes");
                check(addr, a, "address");
            end
        end
        check(rsp_valid, 1, "response");
        rd = rdata;
        tick(2);
        check({cs01, cs2, cs67, rnw}, 4'hF, "idle pins");
    endtask
    task automatic set_cfg(input logic [3:0] v);
        cfg = v;
        cfg_wr = 1;
        tick();
        cfg_wr = 0;
        tick(8);
        check(cfg_q, v, "config");
    endtask
    task automatic clk_scn(input int exp);
        logic prev;
        int n;
        n = 0;
        for (int i = 0; i < 48; i++) begin
            prev = bclk;
            tick();
            n += (bclk !== prev);
        end
        check(n, exp, "bus clock edges");
    endtask
    task automatic rw_scn();
        logic [2:0] zl [6] = '{0, 1, 2, 6, 7, 3};
        logic [15:0] rd;
        int low;
        foreach (zl[i]) begin
            access(1, zl[i], 19'h7FFF0 | zl[i], 16'hC3A0 ^ zl[i], 0, rd, low);
            check(low, exp_low(zl[i]), "write width");
            access(0, zl[i], 19'h7FFF0 | zl[i], 16'h0000, 0, rd, low);
            check(low, exp_low(zl[i]), "read width");
            check(rd, (zl[i] == 3) ? 0 : 16'hC3A0 ^ zl[i], "rdata");
        end
    endtask
    task automatic wait_scn(input logic [3:0] mode);
        logic [15:0] rd;
        int low;
        set_cfg(mode);
        dly = 8'h06;
        access(1, 7, 19'h1234B, 16'h5A0F ^ mode, 0, rd, low);
        access(0, 7, 19'h1234B, 16'h0000, 0, rd, low);
        check(low > 2 && low < 20, 1, "ready stretch");
        check(rd, 16'h5A0F ^ mode, "ready rdata");
        dly = 8'h00;
    endtask
    task automatic hold_scn(input logic mid);
        logic [15:0] rd;
        int low;
        dly = 8'h0A;
        if (mid)
            access(0, 7, 19'h00007, 16'h0000, 1, rd, low);
        req_n = 0;
        for (int i = 0; i < 20 && grant_n !== 1'b0; i++) tick();
        check(grant_n, 0, "grant");
        check({ctl_oe, data_oe}, 0, "pins released");
        req_n = 1;
        for (int i = 0; i < 20 && grant_n !== 1'b1; i++) tick();
        check({grant_n, ctl_oe}, 2'h3, "grant dropped");
        dly = 8'h00;
    endtask
    task automatic final_report();
        if (miscompares == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        tick(12);
        reset_in = 0;
        tick(2);
        check(cfg_q, 4'h2, "reset config");
        check({grant_n, rnw, wr_n, rd_n}, 4'hF, "reset pins");
        clk_scn(12);
        rw_scn();
        wait_scn(4'h2);
        wait_scn(4'h6);
        hold_scn(0);
        hold_scn(1);
        set_cfg(4'h0);
        clk_scn(48);
        set_cfg(4'h1);
        clk_scn(24);
        set_cfg(4'h3);
        clk_scn(12);
        set_cfg(4'hA);
        clk_scn(0);
        final_report();
    end
endmodule
